// ---- dv/capture_record_eth_framer_tb.sv ----
// capture_record_eth_framer_tb: random frames in, records compared with a queue model
// assumes the framer package and host_store_model; small store depth to reach the snap case
`timescale 1ns/100ps
module capture_record_eth_framer_tb;
    import capture_record_pkg::*;
    localparam int DEPTH_T = 64;
    localparam logic [6:0] MODE_CODE [4] = '{7'h02, 7'h0b, 7'h10, 7'h14};
    localparam logic [6:0] ALL_CODES [24] = '{sonet_hdlc_code, ethernet_record_code,
        atm_cell_code, aal5_code, mc_hdlc_code, mc_timeslot_code, mc_atm_code,
        mc_raw_channel_code, mc_aal5_code, colored_sonet_code, colored_ethernet_record_code,
        mc_aal2_code, ip_count_record_code, tcp_flow_count_record_code, dsm_colored_sonet_code,
        dsm_colored_ethernet_code, colored_mc_hdlc_code, aal2_code, hashed_colored_sonet_code,
        hashed_colored_ethernet_code, infiniband_code, ipv4_record_code, ipv6_record_code,
        raw_link_code};
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    byte_beat_s line_i = '0;
    frame_meta_s meta_i = '0;
    byte_beat_s rec_o;
    byte_beat_s got;
    logic rec_ready;
    logic busy_o;
    logic slow = 1'b0;
    int miscompares = 0;
    int cmp_count = 0;
    int last_cnt = 0;
    int rec_cnt = 0;
    int loss = 0;
    logic [7:0] got_q[$];
    logic [7:0] exp_q[$];

    always #2 clk_sys_i = ~clk_sys_i;

    capture_record_eth_framer #(.DEPTH(DEPTH_T)) capture_record_eth_framer_i (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .line_i(line_i), .meta_i(meta_i),
        .rec_ready_i(rec_ready), .rec_o(rec_o), .busy_o(busy_o));

    host_store_model host_store_model_i (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .rec_i(rec_o), .slow_i(slow),
        .ready_o(rec_ready), .got_o(got));

    always @(posedge clk_sys_i) begin
        if (got.valid === 1'b1) begin
            got_q.push_back(got.data);
            if (got.last === 1'b1) last_cnt++;
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // drop marks a frame offered while a record is still going out
    task automatic send_frame(input int n, input int mode, input logic ext, input logic drop);
        frame_meta_s m;
        logic [7:0] d[$];
        int stored;
        logic [15:0] rlen;
        logic [15:0] slot;
        m.stamp = {$urandom, $urandom};
        m.mode = capture_mode_e'(mode);
        m.color = 16'($urandom);
        m.ext_present = ext;
        m.ext_word = {$urandom, $urandom};
        for (int i = 0; i < n; i++) d.push_back(8'($urandom));
        stored = (n > DEPTH_T) ? DEPTH_T : n;
        rlen = 16'(16 + (ext ? 8 : 0) + 2 + stored);
        slot = (mode == 0) ? 16'(loss) : m.color;
        if (drop) begin
            loss++;
        end else begin
            loss = 0;
            rec_cnt++;
            for (int i = 7; i >= 0; i--) exp_q.push_back(m.stamp[i*8 +: 8]);
            exp_q.push_back({ext, MODE_CODE[mode]});
            exp_q.push_back(8'h00);
            exp_q.push_back(rlen[15:8]);
            exp_q.push_back(rlen[7:0]);
            exp_q.push_back(slot[15:8]);
            exp_q.push_back(slot[7:0]);
            exp_q.push_back(8'(n >> 8));
            exp_q.push_back(8'(n));
            if (ext) for (int i = 7; i >= 0; i--) exp_q.push_back(m.ext_word[i*8 +: 8]);
            exp_q.push_back(8'h00);
            exp_q.push_back(8'h00);
            for (int i = 0; i < stored; i++) exp_q.push_back(d[i]);
        end
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys_i);
            if ($urandom_range(3) == 0) begin
                line_i <= '0;
                @(posedge clk_sys_i);
            end
            line_i <= '{1'b1, (i == n - 1), d[i]};
            meta_i <= m;
        end
        @(posedge clk_sys_i);
        line_i <= '0;
    endtask

    task automatic take_record(input logic ext);
        int k;
        int off;
        k = 0;
        off = ext ? 24 : 16;
        // a record of at least nineteen bytes is still going out here
        @(negedge clk_sys_i);
        chk("busy during record", 16'h0001, {15'h0000, busy_o});
        while (last_cnt < rec_cnt && k < 5000) begin
            @(posedge clk_sys_i);
            k++;
        end
        if (k >= 5000) begin
            miscompares++;
            end_of_test();
        end
        @(negedge clk_sys_i);
        chk("busy after record", 16'h0000, {15'h0000, busy_o});
        chk("record size", 16'(exp_q.size()), 16'(got_q.size()));
        chk("length field", 16'(got_q.size()), {got_q[10], got_q[11]});
        chk("type byte", {8'h00, exp_q[8]}, {8'h00, got_q[8]});
        chk("reserved code", 16'h0000, {15'h0000, got_q[8][6:0] inside {[32:47]}});
        chk("loss slot", {exp_q[12], exp_q[13]}, {got_q[12], got_q[13]});
        chk("offset byte", 16'h0000, {8'h00, got_q[off]});
        chk("pad byte", 16'h0000, {8'h00, got_q[off + 1]});
        for (int i = 0; i < exp_q.size(); i++) begin
            chk("record byte", {8'h00, exp_q[i]}, {8'h00, got_q[i]});
        end
        exp_q.delete();
        got_q.delete();
    endtask

    initial begin
        int k;
        logic e;
        void'($urandom(35095));
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            chk("code table", 16'(i + 1), {9'h000, ALL_CODES[i]});
        end
        chk("pad record code", 16'h0030, {9'h000, pad_record_code});
        // every mode with and without an extension header, host prompt or stalling
        for (int m = 0; m < 4; m++) begin
            for (int x = 0; x < 2; x++) begin
                e = x[0];
                slow <= $urandom_range(1);
                send_frame($urandom_range(60, 1), m, e, 1'b0);
                take_record(e);
            end
        end
        // boundary lengths: one byte, a full store and a snapped frame
        send_frame(1, 0, 1'b0, 1'b0);
        take_record(1'b0);
        send_frame(DEPTH_T, 0, 1'b1, 1'b0);
        take_record(1'b1);
        send_frame(DEPTH_T + 7, 0, 1'b0, 1'b0);
        take_record(1'b0);
        // a frame offered during a slow drain is lost and counted in the next plain record
        slow <= 1'b1;
        send_frame(40, 0, 1'b0, 1'b0);
        k = 0;
        while (rec_o.valid !== 1'b1 && k < 200) begin
            @(negedge clk_sys_i);
            k++;
        end
        if (k >= 200) begin
            miscompares++;
            end_of_test();
        end
        send_frame(6, 1, 1'b0, 1'b1);
        take_record(1'b0);
        slow <= 1'b0;
        send_frame(20, 0, 1'b0, 1'b0);
        take_record(1'b0);
        end_of_test();
    end
endmodule // capture_record_eth_framer_tb

// ---- dv/host_store_model.sv ----
// host_store_model: host storage sink that drains framer records byte by byte
// assumes the framer's record stream and one shared clock; slow_i makes the host stall at random
`timescale 1ns/100ps
module host_store_model (
    input wire logic clk_sys_i,                      // system clock
    input wire logic rst_i,                          // async reset, active high
    input wire capture_record_pkg::byte_beat_s rec_i, // record bytes from the framer
    input wire logic slow_i,                         // stall at random when high
    output logic ready_o,                            // byte accepted at this edge
    output capture_record_pkg::byte_beat_s got_o     // accepted byte, one cycle pulse
);
    import capture_record_pkg::*;

    // bytes are stored opaque, offset contents are never interpreted
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ready_o <= 1'b0;
            got_o <= '0;
        end else begin
            got_o <= (rec_i.valid && ready_o) ? rec_i : '0;
            ready_o <= slow_i ? ($urandom_range(2) == 0) : 1'b1;
        end
    end
endmodule // host_store_model

// ---- rtl/capture_record_eth_framer.sv ----
// capture_record_eth_framer: wraps each ethernet frame that starts while idle into a variable-length capture record
// assumes line bytes and meta come from same-clock logic; host drains with valid/ready
`timescale 1ns/100ps
module capture_record_eth_framer #(
    parameter int DEPTH = capture_record_pkg::DEFAULT_DEPTH,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk_sys_i,                          // 250 MHz system clock
    input wire logic rst_i,                              // async reset, active high
    input wire capture_record_pkg::byte_beat_s line_i,   // frame bytes from the line side
    input wire capture_record_pkg::frame_meta_s meta_i,  // sampled with first frame byte
    input wire logic rec_ready_i,                        // host accepts a record byte
    output capture_record_pkg::byte_beat_s rec_o,        // record bytes toward host storage
    output logic busy_o                                  // a record is being built or emitted; clears a cycle after the last byte loads, taken or not
);
    import capture_record_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CAPTURE,
        ST_EMIT
    } phase_e;

    phase_e phase_reg, phase_next;
    frame_meta_s meta_reg, meta_next;
    logic [15:0] len_reg, len_next;
    logic [15:0] wire_reg, wire_next;
    logic [15:0] pos_reg, pos_next;
    logic [15:0] loss_reg, loss_next;
    logic [15:0] loss_snap_reg, loss_snap_next;
    logic drop_reg, drop_next;
    byte_beat_s out_reg, out_next;
    logic busy_reg, busy_next;

    logic out_adv;
    logic frame_start;
    logic drop_hit;
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [AW-1:0] rd_addr;
    logic [7:0] rd_data;
    logic [15:0] payload_start;
    logic [15:0] rec_len;
    logic [6:0] type_code;
    logic [15:0] slot_value;
    rec_header_s hdr;
    logic [7:0] emit_byte;

    function automatic logic [7:0] pick_hdr(input logic [127:0] w, input logic [3:0] idx);
        pick_hdr = w[8*(HDR_BYTES-1-int'(idx)) +: 8];
    endfunction

    function automatic logic [7:0] pick_ext(input logic [63:0] w, input logic [2:0] idx);
        pick_ext = w[8*(EXT_BYTES-1-int'(idx)) +: 8];
    endfunction

    always_comb begin
        case (meta_reg.mode)
            MODE_PLAIN: type_code = ethernet_record_code;
            MODE_COLOR: type_code = colored_ethernet_record_code;
            MODE_DSM: type_code = dsm_colored_ethernet_code;
            MODE_HASH: type_code = hashed_colored_ethernet_code;
            default: type_code = ethernet_record_code;
        endcase
        // loss count only in the plain record, color value otherwise
        slot_value = (meta_reg.mode == MODE_PLAIN) ? loss_snap_reg : meta_reg.color;
    end

    // header, optional extension, offset and pad come before the frame bytes
    assign payload_start = 16'(HDR_BYTES + OFFSET_PAD_BYTES)
        + (meta_reg.ext_present ? 16'(EXT_BYTES) : 16'h0000);
    assign rec_len = payload_start + len_reg;

    always_comb begin
        hdr.stamp = meta_reg.stamp;
        hdr.type_byte = {meta_reg.ext_present, type_code};
        hdr.flags = FLAGS_VALUE;
        hdr.rec_len = rec_len;
        hdr.loss_count_slot = slot_value;
        hdr.wire_len = wire_reg;
    end

    always_comb begin
        if (pos_reg < 16'(HDR_BYTES)) begin
            emit_byte = pick_hdr(hdr, pos_reg[3:0]);
        end else if (pos_reg < payload_start - 16'(OFFSET_PAD_BYTES)) begin
            emit_byte = pick_ext(meta_reg.ext_word, pos_reg[2:0]);
        end else if (pos_reg == payload_start - 16'(OFFSET_PAD_BYTES)) begin
            emit_byte = OFFSET_FIELD_VALUE;
        end else if (pos_reg == payload_start - 16'h0001) begin
            emit_byte = PAD_BYTE_VALUE;
        end else begin
            emit_byte = rd_data;
        end
    end

    assign out_adv = !out_reg.valid || rec_ready_i;
    assign frame_start = (phase_reg == ST_IDLE) && line_i.valid && !drop_reg;
    // the line cannot be stalled, so a frame that starts while a record drains is lost
    assign drop_hit = line_i.valid && !drop_reg && (phase_reg == ST_EMIT);
    assign wr_en = (frame_start || ((phase_reg == ST_CAPTURE) && line_i.valid))
        && (len_reg < 16'(DEPTH) || frame_start);
    assign wr_addr = frame_start ? '0 : len_reg[AW-1:0];
    // read one byte ahead: the store answers for pos_reg once pos_next settles
    assign rd_addr = AW'(pos_next - payload_start);

    always_comb begin
        phase_next = phase_reg;
        meta_next = meta_reg;
        len_next = len_reg;
        wire_next = wire_reg;
        pos_next = pos_reg;
        loss_snap_next = loss_snap_reg;
        out_next = out_reg;
        busy_next = busy_reg;
        drop_next = drop_reg;
        if (out_adv) begin
            out_next.valid = 1'b0;
        end
        case (phase_reg)
            ST_IDLE: begin
                busy_next = 1'b0;
                if (frame_start) begin
                    meta_next = meta_i;
                    len_next = 16'h0001;
                    wire_next = 16'h0001;
                    loss_snap_next = loss_reg;
                    pos_next = 16'h0000;
                    busy_next = 1'b1;
                    phase_next = line_i.last ? ST_EMIT : ST_CAPTURE;
                end
            end
            ST_CAPTURE: begin
                if (line_i.valid) begin
                    // long frames are snapped at the store depth, wire length stays true
                    if (len_reg < 16'(DEPTH)) begin
                        len_next = len_reg + 16'h0001;
                    end
                    wire_next = wire_reg + 16'h0001;
                    if (line_i.last) begin
                        phase_next = ST_EMIT;
                    end
                end
            end
            ST_EMIT: begin
                if (out_adv) begin
                    out_next.valid = 1'b1;
                    out_next.data = emit_byte;
                    out_next.last = (pos_reg == rec_len - 16'h0001);
                    pos_next = pos_reg + 16'h0001;
                    if (pos_reg == rec_len - 16'h0001) begin
                        phase_next = ST_IDLE;
                    end
                end
            end
            default: phase_next = ST_IDLE;
        endcase
        if (line_i.valid && (drop_reg || drop_hit)) begin
            drop_next = !line_i.last;
        end
    end

    // a drop in the same cycle as the snapshot clear still counts
    always_comb begin
        loss_next = frame_start ? 16'h0000 : loss_reg;
        if (drop_hit && loss_next != LOSS_MAX) begin
            loss_next = loss_next + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            phase_reg <= ST_IDLE;
            meta_reg <= '0;
            len_reg <= 16'h0000;
            wire_reg <= 16'h0000;
            pos_reg <= 16'h0000;
            loss_reg <= 16'h0000;
            loss_snap_reg <= 16'h0000;
            drop_reg <= 1'b0;
            out_reg <= '0;
            busy_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            meta_reg <= meta_next;
            len_reg <= len_next;
            wire_reg <= wire_next;
            pos_reg <= pos_next;
            loss_reg <= loss_next;
            loss_snap_reg <= loss_snap_next;
            drop_reg <= drop_next;
            out_reg <= out_next;
            busy_reg <= busy_next;
        end
    end

    frame_store #(
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_store (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .wr_en_i(wr_en),
        .wr_addr_i(wr_addr),
        .wr_data_i(line_i.data),
        .rd_addr_i(rd_addr),
        .rd_data_o(rd_data)
    );

    assign rec_o = out_reg;
    assign busy_o = busy_reg;

    logic emit_fire;
    assign emit_fire = (phase_reg == ST_EMIT) && out_adv;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    chk_ext_flag_bit: assert property (
        emit_fire && pos_reg == 16'(TYPE_BYTE_POS)
        |=> rec_o.valid && rec_o.data[EXT_FLAG_BIT] == $past(meta_reg.ext_present))
        else $error("extension flag bit does not match extension presence");
    chk_plain_type_code: assert property (
        emit_fire && pos_reg == 16'(TYPE_BYTE_POS) && meta_reg.mode == MODE_PLAIN
        |=> rec_o.data[6:0] == ethernet_record_code)
        else $error("plain ethernet record carries wrong type code");
    chk_variant_type_code: assert property (
        emit_fire && pos_reg == 16'(TYPE_BYTE_POS) && meta_reg.mode != MODE_PLAIN
        |=> rec_o.data[6:0] == (($past(meta_reg.mode) == MODE_COLOR) ? 7'h0b :
            ($past(meta_reg.mode) == MODE_DSM) ? 7'h10 : 7'h14))
        else $error("colored variant carries wrong type code");
    chk_no_reserved_code: assert property (
        emit_fire && pos_reg == 16'(TYPE_BYTE_POS)
        |=> !(rec_o.data[6:0] >= reserved_code_lo && rec_o.data[6:0] <= reserved_code_hi))
        else $error("reserved type code produced");
    chk_offset_zero: assert property (
        emit_fire && pos_reg == payload_start - 16'h0002 |=> rec_o.data == 8'h00)
        else $error("offset byte not zero");
    chk_pad_then_frame: assert property (
        emit_fire && pos_reg == payload_start - 16'h0001
        |=> rec_o.data == 8'h00 && !rec_o.last)
        else $error("pad byte wrong or record ended at pad");
    chk_record_end: assert property (
        emit_fire && pos_reg == rec_len - 16'h0001
        |=> rec_o.valid && rec_o.last && phase_reg == ST_IDLE
            && $past(rec_len) == $past(payload_start) + $past(len_reg))
        else $error("record did not end at its length");
    // the low length byte is loaded by the emit step that follows the high byte
    chk_len_field: assert property (
        emit_fire && pos_reg == 16'(LEN_MSB_POS + 1)
        |=> rec_o.valid && rec_o.data == $past(rec_len[7:0]))
        else $error("record length low byte wrong");
    chk_loss_count: assert property (
        drop_hit && !frame_start && loss_reg != LOSS_MAX |=> loss_reg == $past(loss_reg) + 16'h0001)
        else $error("dropped frame not counted");
    chk_hold_stall: assert property (
        rec_o.valid && !rec_ready_i |=> $stable(rec_o))
        else $error("record byte changed under back-pressure");

    cov_ext_record: cover property (emit_fire && meta_reg.ext_present && rec_len == pos_reg + 16'h0001);
    cov_drop: cover property (drop_hit);
    cov_color_record: cover property (emit_fire && meta_reg.mode == MODE_COLOR);
    cov_stall: cover property (rec_o.valid && !rec_ready_i ##1 rec_ready_i);
endmodule // capture_record_eth_framer

// ---- rtl/capture_record_pkg.sv ----
// capture_record_pkg: constants, type codes and carriers for the ethernet capture record framer
// assumes a single 250 MHz clock domain shared by line side, meta source and host side
package capture_record_pkg;

    // record layout, in bytes; EXT_FLAG_BIT is a bit of the type byte
    localparam int HDR_BYTES = 16;
    localparam int EXT_BYTES = 8;
    localparam int OFFSET_PAD_BYTES = 2;
    localparam int TYPE_BYTE_POS = 8;
    localparam int LEN_MSB_POS = 10;
    localparam int EXT_FLAG_BIT = 7;
    localparam int DEFAULT_DEPTH = 2048;

    localparam logic [7:0] OFFSET_FIELD_VALUE = 8'h00;
    localparam logic [7:0] PAD_BYTE_VALUE = 8'h00;
    localparam logic [7:0] FLAGS_VALUE = 8'h00;
    localparam logic [15:0] LOSS_MAX = 16'hffff;

    // record type codes, low seven bits of the type byte
    localparam logic [6:0] old_style_record_code = 7'h00;
    localparam logic [6:0] sonet_hdlc_code = 7'h01;
    localparam logic [6:0] ethernet_record_code = 7'h02;
    localparam logic [6:0] atm_cell_code = 7'h03;
    localparam logic [6:0] aal5_code = 7'h04;
    localparam logic [6:0] mc_hdlc_code = 7'h05;
    localparam logic [6:0] mc_timeslot_code = 7'h06;
    localparam logic [6:0] mc_atm_code = 7'h07;
    localparam logic [6:0] mc_raw_channel_code = 7'h08;
    localparam logic [6:0] mc_aal5_code = 7'h09;
    localparam logic [6:0] colored_sonet_code = 7'h0a;
    localparam logic [6:0] colored_ethernet_record_code = 7'h0b;
    localparam logic [6:0] mc_aal2_code = 7'h0c;
    localparam logic [6:0] ip_count_record_code = 7'h0d;
    localparam logic [6:0] tcp_flow_count_record_code = 7'h0e;
    localparam logic [6:0] dsm_colored_sonet_code = 7'h0f;
    localparam logic [6:0] dsm_colored_ethernet_code = 7'h10;
    localparam logic [6:0] colored_mc_hdlc_code = 7'h11;
    localparam logic [6:0] aal2_code = 7'h12;
    localparam logic [6:0] hashed_colored_sonet_code = 7'h13;
    localparam logic [6:0] hashed_colored_ethernet_code = 7'h14;
    localparam logic [6:0] infiniband_code = 7'h15;
    localparam logic [6:0] ipv4_record_code = 7'h16;
    localparam logic [6:0] ipv6_record_code = 7'h17;
    localparam logic [6:0] raw_link_code = 7'h18;
    localparam logic [6:0] reserved_code_lo = 7'h20;
    localparam logic [6:0] reserved_code_hi = 7'h2f;
    localparam logic [6:0] pad_record_code = 7'h30;

    typedef enum logic [1:0] {
        MODE_PLAIN,
        MODE_COLOR,
        MODE_DSM,
        MODE_HASH
    } capture_mode_e;

    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } byte_beat_s;

    typedef struct packed {
        logic [63:0] stamp;
        capture_mode_e mode;
        logic [15:0] color;
        logic ext_present;
        logic [63:0] ext_word;
    } frame_meta_s;

    typedef struct packed {
        logic [63:0] stamp;
        logic [7:0] type_byte;
        logic [7:0] flags;
        logic [15:0] rec_len;
        logic [15:0] loss_count_slot;
        logic [15:0] wire_len;
    } rec_header_s;

endpackage

// ---- rtl/frame_store.sv ----
// frame_store: simple dual-port byte store holding one captured frame
// assumes one write and one read port on the same clock; read data is registered
`timescale 1ns/100ps
module frame_store #(
    parameter int DEPTH = 2048,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk_sys_i,           // system clock
    input wire logic rst_i,               // async reset, active high
    input wire logic wr_en_i,             // write strobe
    input wire logic [AW-1:0] wr_addr_i,  // write address
    input wire logic [7:0] wr_data_i,     // write byte
    input wire logic [AW-1:0] rd_addr_i,  // read address, sampled every cycle
    output logic [7:0] rd_data_o          // byte at last cycle's read address
);
    logic [7:0] mem [DEPTH];
    logic [7:0] rd_data_reg;

    // array has no reset so it maps onto block ram
    always_ff @(posedge clk_sys_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_reg <= 8'h00;
        end else begin
            rd_data_reg <= mem[rd_addr_i];
        end
    end

    assign rd_data_o = rd_data_reg;
endmodule // frame_store
